// ==== rst_wdog_pkg.sv ====
// Purpose: shared constants for the reset controller and watchdog
// Assumes: 32-bit apb data, 250 MHz bus clock
// Notes: every register takes one aligned word
`default_nettype none

package rst_wdog_pkg;
  // ==========================================================
  // register map
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFF_CAUSE = 8'h00;
  localparam logic [7:0] OFF_OPT1 = 8'h04;
  localparam logic [7:0] OFF_OPT2 = 8'h08;
  localparam logic [7:0] OFF_COUNT = 8'h0c;
  // ==========================================================
  // reset cause bit positions
  localparam int CAUSE_POR = 7;
  localparam int CAUSE_PIN = 6;
  localparam int CAUSE_WDOG = 5;
  localparam int CAUSE_BAD_OP = 4;
  localparam int CAUSE_BAD_ADDR = 3;
  localparam int CAUSE_CLK_LOSS = 2;
  localparam int CAUSE_LOW_VOLT = 1;
  localparam logic [7:0] CAUSE_POR_VALUE = 8'h80;
  // ==========================================================
  // service values and cpu start state
  localparam logic [31:0] SERVICE_FIRST = 32'h00000055;
  localparam logic [31:0] SERVICE_SECOND = 32'h000000aa;
  localparam logic [15:0] VECTOR_HI_ADDR = 16'hfffe;
  localparam logic [15:0] VECTOR_LO_ADDR = 16'hffff;
  localparam logic [15:0] STACK_INIT = 16'h00ff;
  // ==========================================================
  // reset pin timing, in bus cycles
  localparam logic [5:0] PIN_DRIVE_CYCLES = 6'h22;
  localparam logic [5:0] PIN_SAMPLE_CYCLES = 6'h26;
  // ==========================================================
  // option defaults and watchdog timeouts (log2 of cycles)
  localparam logic [1:0] TSEL_OFF = 2'h0;
  localparam logic [1:0] TSEL_RESET = 2'h3;
  localparam logic CLKSEL_RESET = 1'b1;
  localparam logic WINDOW_RESET = 1'b0;
  localparam int CNT_W = 18;
  localparam logic [4:0] BUS_EXP_S = 5'h0d;
  localparam logic [4:0] BUS_EXP_M = 5'h10;
  localparam logic [4:0] BUS_EXP_L = 5'h12;
  localparam logic [4:0] ONEK_EXP_S = 5'h05;
  localparam logic [4:0] ONEK_EXP_M = 5'h08;
  localparam logic [4:0] ONEK_EXP_L = 5'h0a;
  // ==========================================================
  // internal 1 kHz tick derived from the bus clock
  localparam int CLK_PERIOD_NS = 4;
  localparam int ONEK_PERIOD_NS = 1000000;
  localparam int ONEK_DIV = ONEK_PERIOD_NS / CLK_PERIOD_NS;
endpackage

`default_nettype wire

// ==== wdog_if.sv ====
// Purpose: links the reset sequencer, tick divider and watchdog counter
// Assumes: all three sit on pclk
// Notes: tick is a one-cycle pulse
`default_nettype none

interface wdog_if;
  logic tick;
  logic run;
  logic clear;
  logic hold;
  logic sel_1k;
  logic [1:0] tsel;
  logic timeout;
  logic in_window;
  logic [rst_wdog_pkg::CNT_W-1:0] count;
  modport divider (output tick);
  modport counter (input tick, run, clear, hold, sel_1k, tsel,
                   output timeout, in_window, count);
  modport ctrl (input timeout, in_window, count,
                output run, clear, hold, sel_1k, tsel);
endinterface

`default_nettype wire

// ==== onek_divider.sv ====
// Purpose: one-cycle tick at 1 kHz from the bus clock
// Assumes: DIV at least 2
// Notes: free running so the slow source never depends on software
`default_nettype none

module onek_divider #(
  parameter int DIV = rst_wdog_pkg::ONEK_DIV
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // tick out
  wdog_if.divider w
);
  localparam int DW = $clog2(DIV);
  localparam logic [DW-1:0] LAST = DW'(DIV - 1);
  typedef struct packed {
    logic [DW-1:0] cnt;
    logic tick;
  } div_s;
  div_s s;
  div_s next_s;

  always_comb begin
    next_s = s;
    next_s.tick = (s.cnt == LAST);
    next_s.cnt = (s.cnt == LAST) ? '0 : s.cnt + DW'(1);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
    end else if (ce) begin
      s <= next_s;
    end
  end

  assign w.tick = s.tick & ce;
endmodule // onek_divider

`default_nettype wire

// ==== wdog_counter.sv ====
// Purpose: watchdog counter with selectable timeout and service window
// Assumes: timeouts are powers of two up to 2**CNT_W
// Notes: timeout is a one-cycle pulse
`default_nettype none

module wdog_counter #(
  parameter int CNT_W = rst_wdog_pkg::CNT_W,
  parameter logic [4:0] BUS_S = rst_wdog_pkg::BUS_EXP_S,
  parameter logic [4:0] BUS_M = rst_wdog_pkg::BUS_EXP_M,
  parameter logic [4:0] BUS_L = rst_wdog_pkg::BUS_EXP_L,
  parameter logic [4:0] ONEK_S = rst_wdog_pkg::ONEK_EXP_S,
  parameter logic [4:0] ONEK_M = rst_wdog_pkg::ONEK_EXP_M,
  parameter logic [4:0] ONEK_L = rst_wdog_pkg::ONEK_EXP_L
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // control and status
  wdog_if.counter w
);
  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic timeout;
  } wc_s;
  wc_s s;
  wc_s next_s;
  logic [4:0] exp_sel;
  logic [CNT_W:0] lim;
  logic step;

  always_comb begin
    unique case (w.tsel)
      2'h1: exp_sel = w.sel_1k ? ONEK_S : BUS_S;
      2'h2: exp_sel = w.sel_1k ? ONEK_M : BUS_M;
      default: exp_sel = w.sel_1k ? ONEK_L : BUS_L;
    endcase
    lim = (CNT_W+1)'(1) << exp_sel;
    // bus clock holds in debug or stop
    step = w.run & !w.hold & (w.sel_1k ? w.tick : 1'b1);
    next_s = s;
    next_s.timeout = step & ({1'b0, s.cnt} == lim - (CNT_W+1)'(1));
    if (step) begin
      next_s.cnt = s.cnt + CNT_W'(1);
    end
    if (w.clear | (w.sel_1k & w.hold)) begin
      next_s.cnt = '0;
      next_s.timeout = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
    end else if (ce) begin
      s <= next_s;
    end
  end

  assign w.in_window = ({1'b0, s.cnt} >= lim - (lim >> 2));
  assign w.timeout = s.timeout;
  assign w.count = s.cnt;
endmodule // wdog_counter

`default_nettype wire

// ==== reset_control_and_watchdog.sv ====
// Purpose: reset sequencer, reset cause capture and service watchdog
// Assumes: vector memory returns data the cycle after vec_rd
// Notes: apb answers with pready one cycle into the access phase
//
// Summary of operation
// - after reset fetch pc from 0xfffe (high) and 0xffff (low)
// - every reset presents stack pointer value 0x00ff
// - every reset sets the interrupt mask bit
// - peripherals disabled and pins safe inputs while in reset
// - eight sources; all but debug-forced have a cause flag
// - any reset drives the reset pin low for 34 cycles
// - 38 cycles after release sample the pin for pin cause
// - watchdog enabled after reset; zero timeout select disables it
// - writes 0x55 then 0xaa to cause address restart the timeout
// - cause register is read only; service writes leave it
// - any other value written there resets immediately
// - counter reaching timeout before service resets the system
// - clock select picks bus or 1 khz, three timeouts each
// - default is the 1 khz clock and the 2**10 timeout
// - bus clock with window on: early service write resets
// - no window when the 1 khz clock is selected
// - counter cleared on reset, first option writes and completed service
// - bus clock: counter holds in debug and stop modes
// - 1 khz clock: counter cleared in debug and stop modes
// - cause register shows the source of the latest reset
`default_nettype none

module reset_control_and_watchdog #(
  parameter int TICK_DIV = rst_wdog_pkg::ONEK_DIV
) (
  // clock, reset, clock enable
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [rst_wdog_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // reset requests, one-cycle pulses
  input wire logic illegal_opcode_cause,
  input wire logic illegal_address_cause,
  input wire logic low_voltage_cause,
  input wire logic clock_loss_cause,
  input wire logic debug_forced_reset,
  // cpu mode levels
  input wire logic debug_active,
  input wire logic stop_active,
  // reset pin, open drain
  input wire logic rst_pin_in,
  output logic rst_pin_out,
  output logic rst_pin_oe,
  // system reset and safe state
  output logic sys_rst_n,
  output logic periph_disable,
  output logic io_force_input,
  // vector fetch
  output logic vec_rd,
  output logic [15:0] vec_addr,
  input wire logic [7:0] vec_rdata,
  // cpu start-up state
  output logic cpu_start,
  output logic [15:0] pc_init,
  output logic [15:0] stack_pointer,
  output logic condition_code_register_i_set
);
  // ==========================================================
  // state
  typedef enum logic [2:0] {
    ST_DRIVE = 3'h0,
    ST_SETTLE = 3'h1,
    ST_VEC_HI = 3'h2,
    ST_VEC_LO = 3'h3,
    ST_VEC_END = 3'h4,
    ST_RUN = 3'h5
  } seq_e;

  typedef struct packed {
    seq_e st;
    logic [5:0] cnt;
    logic [7:0] cause;
    logic [15:0] pc;
    logic [15:0] stk;
    logic i_set;
    logic vec_rd;
    logic [15:0] vec_addr;
    logic cpu_start;
    logic in_reset;
    logic pin_oe;
    logic [1:0] tsel;
    logic clk_sel;
    logic win_en;
    logic opt1_done;
    logic opt2_done;
    logic armed;
    logic wd_clear;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } ctl_s;

  ctl_s s;
  ctl_s next_s;
  wdog_if w ();

  // ==========================================================
  // watchdog pieces
  onek_divider #(
    .DIV(TICK_DIV)
  ) u_div (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .w(w.divider)
  );

  wdog_counter u_cnt (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .w(w.counter)
  );

  assign w.run = (s.st == ST_RUN) & (s.tsel != rst_wdog_pkg::TSEL_OFF);
  assign w.clear = s.wd_clear;
  assign w.hold = debug_active | stop_active;
  assign w.sel_1k = s.clk_sel;
  assign w.tsel = s.tsel;

  // ==========================================================
  // next state
  logic access;
  logic wr;
  logic svc_val;
  logic early;
  logic [7:0] src;

  always_comb begin
    next_s = s;
    next_s.vec_rd = 1'b0;
    next_s.cpu_start = 1'b0;
    next_s.i_set = 1'b0;
    next_s.wd_clear = 1'b0;
    src = 8'h00;
    access = psel & penable;
    wr = access & s.pready & pwrite & (s.st == ST_RUN);
    svc_val = (pwdata == rst_wdog_pkg::SERVICE_FIRST) |
              (pwdata == rst_wdog_pkg::SERVICE_SECOND);
    // window only on the bus clock
    early = !s.clk_sel & s.win_en & w.run & !w.in_window;

    // apb answer: one wait state, then pready for one cycle
    next_s.pready = access & !s.pready;
    if (access & !s.pready) begin
      next_s.pslverr = 1'b0;
      unique case (paddr)
        rst_wdog_pkg::OFF_CAUSE: next_s.prdata = {24'h0, s.cause};
        rst_wdog_pkg::OFF_OPT1: next_s.prdata = {30'h0, s.tsel};
        rst_wdog_pkg::OFF_OPT2: next_s.prdata = {30'h0, s.win_en, s.clk_sel};
        rst_wdog_pkg::OFF_COUNT:
          next_s.prdata = (32)'(w.count);
        default: begin
          next_s.prdata = 32'h0;
          next_s.pslverr = 1'b1;
        end
      endcase
    end else if (!access) begin
      next_s.pslverr = 1'b0;
      next_s.prdata = 32'h0;
    end

    unique case (s.st)
      // drive the pin low for 34 cycles
      ST_DRIVE: begin
        next_s.pin_oe = 1'b1;
        next_s.cnt = s.cnt + 6'h01;
        if (s.cnt == rst_wdog_pkg::PIN_DRIVE_CYCLES - 6'h01) begin
          next_s.pin_oe = 1'b0;
          next_s.cnt = 6'h00;
          next_s.st = ST_SETTLE;
        end
      end
      // sample the released pin after 38 cycles
      ST_SETTLE: begin
        next_s.cnt = s.cnt + 6'h01;
        if (s.cnt == rst_wdog_pkg::PIN_SAMPLE_CYCLES - 6'h01) begin
          next_s.cnt = 6'h00;
          if (!rst_pin_in) begin
            // pin held low outside: it is the cause, wait for release
            next_s.cause = 8'h00;
            next_s.cause[rst_wdog_pkg::CAUSE_PIN] = 1'b1;
          end else begin
            next_s.vec_rd = 1'b1;
            next_s.vec_addr = rst_wdog_pkg::VECTOR_HI_ADDR;
            next_s.st = ST_VEC_HI;
          end
        end
      end
      ST_VEC_HI: begin
        next_s.vec_rd = 1'b1;
        next_s.vec_addr = rst_wdog_pkg::VECTOR_LO_ADDR;
        next_s.st = ST_VEC_LO;
      end
      ST_VEC_LO: begin
        next_s.pc[15:8] = vec_rdata;
        next_s.st = ST_VEC_END;
      end
      ST_VEC_END: begin
        next_s.pc[7:0] = vec_rdata;
        next_s.cpu_start = 1'b1;
        next_s.stk = rst_wdog_pkg::STACK_INIT;
        next_s.i_set = 1'b1;
        next_s.in_reset = 1'b0;
        // counter starts fresh out of reset
        next_s.wd_clear = 1'b1;
        next_s.st = ST_RUN;
      end
      ST_RUN: begin
        src[rst_wdog_pkg::CAUSE_BAD_OP] = illegal_opcode_cause;
        src[rst_wdog_pkg::CAUSE_BAD_ADDR] = illegal_address_cause;
        src[rst_wdog_pkg::CAUSE_LOW_VOLT] = low_voltage_cause;
        src[rst_wdog_pkg::CAUSE_CLK_LOSS] = clock_loss_cause;
        src[rst_wdog_pkg::CAUSE_PIN] = !rst_pin_in;
        src[rst_wdog_pkg::CAUSE_WDOG] = w.timeout;
        if (wr) begin
          unique case (paddr)
            rst_wdog_pkg::OFF_CAUSE: begin
              if (!svc_val | early) begin
                src[rst_wdog_pkg::CAUSE_WDOG] = 1'b1;
              end else if (pwdata == rst_wdog_pkg::SERVICE_FIRST) begin
                next_s.armed = 1'b1;
              end else if (s.armed) begin
                next_s.armed = 1'b0;
                next_s.wd_clear = 1'b1;
              end
            end
            rst_wdog_pkg::OFF_OPT1: begin
              if (!s.opt1_done) begin
                next_s.tsel = pwdata[1:0];
                next_s.opt1_done = 1'b1;
                next_s.wd_clear = 1'b1;
              end
            end
            rst_wdog_pkg::OFF_OPT2: begin
              if (!s.opt2_done) begin
                next_s.clk_sel = pwdata[0];
                next_s.win_en = pwdata[1];
                next_s.opt2_done = 1'b1;
                next_s.wd_clear = 1'b1;
              end
            end
            default: begin
              next_s.armed = s.armed;
            end
          endcase
        end
        if ((src != 8'h00) | debug_forced_reset) begin
          // latest cause replaces the old one
          next_s.cause = src;
          next_s.st = ST_DRIVE;
          next_s.cnt = 6'h00;
          next_s.pin_oe = 1'b1;
          // safe state for the whole sequence
          next_s.in_reset = 1'b1;
          next_s.tsel = rst_wdog_pkg::TSEL_RESET;
          next_s.clk_sel = rst_wdog_pkg::CLKSEL_RESET;
          next_s.win_en = rst_wdog_pkg::WINDOW_RESET;
          next_s.opt1_done = 1'b0;
          next_s.opt2_done = 1'b0;
          next_s.armed = 1'b0;
          next_s.wd_clear = 1'b1;
          next_s.i_set = 1'b1;
        end
      end
      default: begin
        next_s.st = ST_DRIVE;
        next_s.cnt = 6'h00;
      end
    endcase
  end

  // ==========================================================
  // registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
      s.st <= ST_DRIVE;
      s.cause <= rst_wdog_pkg::CAUSE_POR_VALUE;
      s.stk <= rst_wdog_pkg::STACK_INIT;
      s.i_set <= 1'b1;
      s.in_reset <= 1'b1;
      s.pin_oe <= 1'b1;
      s.tsel <= rst_wdog_pkg::TSEL_RESET;
      s.clk_sel <= rst_wdog_pkg::CLKSEL_RESET;
      s.win_en <= rst_wdog_pkg::WINDOW_RESET;
      s.wd_clear <= 1'b1;
    end else if (ce) begin
      s <= next_s;
    end
  end

  // ==========================================================
  // outputs
  assign prdata = s.prdata;
  assign pready = s.pready;
  assign pslverr = s.pslverr;
  // open drain pin only ever pulls low
  assign rst_pin_out = 1'b0;
  assign rst_pin_oe = s.pin_oe;
  assign sys_rst_n = !s.in_reset;
  assign periph_disable = s.in_reset;
  assign io_force_input = s.in_reset;
  assign vec_rd = s.vec_rd;
  assign vec_addr = s.vec_addr;
  assign cpu_start = s.cpu_start;
  assign pc_init = s.pc;
  assign stack_pointer = s.stk;
  assign condition_code_register_i_set = s.i_set;
endmodule // reset_control_and_watchdog

`default_nettype wire

// ==== rst_wdog_monitor.sv ====
// Purpose: port-level checks of reset sequencing and watchdog resets
// Assumes: one pclk domain, presetn asynchronous and active low
// Notes: bound to the top module at the foot of this file
`default_nettype none

module rst_wdog_monitor (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [rst_wdog_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  // reset request and pin
  input wire logic debug_forced_reset,
  input wire logic rst_pin_oe,
  // reset state and start-up
  input wire logic sys_rst_n,
  input wire logic periph_disable,
  input wire logic io_force_input,
  input wire logic vec_rd,
  input wire logic [15:0] vec_addr,
  input wire logic cpu_start,
  input wire logic [15:0] stack_pointer,
  input wire logic condition_code_register_i_set
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ==========================================================
  // helper counters: pin drive length and time since release
  logic [6:0] oe_len;
  logic [6:0] rel_len;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      oe_len <= 7'h00;
      rel_len <= 7'h00;
    end else begin
      oe_len <= rst_pin_oe ? oe_len + 7'h01 : 7'h00;
      // saturate so a long run never wraps back under the bound
      if (rst_pin_oe)
        rel_len <= 7'h00;
      else if (rel_len != 7'h7f)
        rel_len <= rel_len + 7'h01;
    end
  end
  // ==========================================================
  // assertions
  property p_drive_len;
    $fell(rst_pin_oe) |-> oe_len == 7'h22;
  endproperty
  a_drive_len: assert property (p_drive_len)
    else $error("reset pin drive length wrong");
  property p_pin_driven;
    $fell(sys_rst_n) |-> ##[0:2] rst_pin_oe;
  endproperty
  a_pin_driven: assert property (p_pin_driven)
    else $error("reset entered without driving the pin");
  property p_sample_wait;
    vec_rd && vec_addr == 16'hfffe |-> rel_len >= 7'h26;
  endproperty
  a_sample_wait: assert property (p_sample_wait)
    else $error("vector fetch before pin sample wait");
  property p_vec_order;
    vec_rd && vec_addr == 16'hfffe |=> vec_rd && vec_addr == 16'hffff;
  endproperty
  a_vec_order: assert property (p_vec_order)
    else $error("vector low byte fetch not next");
  property p_start_state;
    cpu_start |-> stack_pointer == 16'h00ff && condition_code_register_i_set;
  endproperty
  a_start_state: assert property (p_start_state)
    else $error("start-up stack or mask wrong");
  property p_safe_state;
    !sys_rst_n |-> periph_disable && io_force_input;
  endproperty
  a_safe_state: assert property (p_safe_state)
    else $error("peripherals or pins not safe in reset");
  property p_bad_write;
    psel && penable && pready && pwrite && !pslverr && sys_rst_n &&
      paddr == 8'h00 && pwdata != 32'h00000055 && pwdata != 32'h000000aa
      |-> ##[1:3] !sys_rst_n;
  endproperty
  a_bad_write: assert property (p_bad_write)
    else $error("bad service value did not reset");
  property p_debug_reset;
    debug_forced_reset && sys_rst_n |-> ##[1:3] !sys_rst_n;
  endproperty
  a_debug_reset: assert property (p_debug_reset)
    else $error("debug forced reset ignored");
endmodule // rst_wdog_monitor

bind reset_control_and_watchdog rst_wdog_monitor rst_wdog_monitor_i (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
  .pslverr, .debug_forced_reset, .rst_pin_oe, .sys_rst_n, .periph_disable,
  .io_force_input, .vec_rd, .vec_addr, .cpu_start, .stack_pointer,
  .condition_code_register_i_set);

`default_nettype wire

// ==== reset_control_and_watchdog_tb.sv ====
// Purpose: self-checking bench for the reset controller and watchdog
// Assumes: vector memory answers the cycle after a fetch strobe
// Notes: tick divider set to 8 so the slow source runs quickly
`default_nettype none

module reset_control_and_watchdog_tb;
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================
  // signals
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000;
  logic [4:0] src = 5'h00;
  logic debug_active = 1'b0;
  logic stop_active = 1'b0;
  logic ext_low = 1'b0;
  logic [7:0] vec_rdata = 8'h00;
  logic rst_pin_in;
  logic [31:0] prdata;
  logic pready, pslverr, rst_pin_out, rst_pin_oe, sys_rst_n, vec_rd;
  logic cpu_start, cc_i_set;
  logic [15:0] vec_addr, pc_init, stack_pointer;
  logic [31:0] rd, hold_val;
  logic err;
  int n;
  int mismatches = 0;
  int checks = 0;
  typedef struct packed { logic [4:0] src; logic [7:0] cause; } row_s;
  // sources: bit0 opcode, 1 address, 2 voltage, 3 clock, 4 debug
  row_s rows [6] = '{'{5'h01, 8'h10}, '{5'h02, 8'h08}, '{5'h04, 8'h02},
                     '{5'h08, 8'h04}, '{5'h10, 8'h00}, '{5'h03, 8'h18}};

  always #2 pclk = ~pclk;
  // open-drain pin with pull-up
  assign rst_pin_in = !((rst_pin_oe && !rst_pin_out) || ext_low);
  // data inverted each cycle outside a fetch so a late read shows up
  always @(posedge pclk) begin
    if (vec_rd)
      vec_rdata <= (vec_addr == 16'hfffe) ? 8'h12 : 8'h34;
    else
      vec_rdata <= ~vec_rdata;
  end

  reset_control_and_watchdog #(.TICK_DIV(8)) reset_control_and_watchdog_i (
    .pclk(pclk), .presetn(presetn), .ce(1'b1), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .illegal_opcode_cause(src[0]), .illegal_address_cause(src[1]),
    .low_voltage_cause(src[2]), .clock_loss_cause(src[3]),
    .debug_forced_reset(src[4]), .debug_active(debug_active),
    .stop_active(stop_active), .rst_pin_in(rst_pin_in),
    .rst_pin_out(rst_pin_out), .rst_pin_oe(rst_pin_oe),
    .sys_rst_n(sys_rst_n), .periph_disable(), .io_force_input(),
    .vec_rd(vec_rd), .vec_addr(vec_addr), .vec_rdata(vec_rdata),
    .cpu_start(cpu_start), .pc_init(pc_init),
    .stack_pointer(stack_pointer), .condition_code_register_i_set(cc_i_set));

  // ==========================================================
  // tasks
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int k = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // pready, data and error are all taken at the ending rising edge
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 40);
    if (k >= 40) chk(32'h00000000, 32'h00000001);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic await_rst(input int lim);
    n = 0;
    while (sys_rst_n !== 1'b0 && n < lim) begin
      @(negedge pclk);
      n++;
    end
    if (n >= lim) chk(32'h00000000, 32'h00000001);
  endtask

  // waits for start-up; lo is the least number of cycles it may take
  task automatic boot(input int lo);
    int k = 0;
    while (cpu_start !== 1'b1 && k < 400) begin
      @(negedge pclk);
      k++;
    end
    chk({31'h0, k >= lo && k < 400}, 32'h00000001);
    chk({16'h0, pc_init}, 32'h00001234);
    chk({16'h0, stack_pointer}, {16'h0, rst_wdog_pkg::STACK_INIT});
    chk({31'h0, cc_i_set}, 32'h00000001);
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // ==========================================================
  // tests
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    boot(72);
    apb(1'b0, 8'h00, 32'h0);
    chk(rd, 32'h00000080);
    apb(1'b0, 8'h04, 32'h0);
    chk(rd, 32'h00000003);
    apb(1'b0, 8'h08, 32'h0);
    chk(rd, 32'h00000001);
    apb(1'b0, 8'h10, 32'h0);
    chk({31'h0, err}, 32'h00000001);
    foreach (rows[i]) begin
      @(posedge pclk);
      src <= rows[i].src;
      @(posedge pclk);
      src <= 5'h00;
      await_rst(10);
      boot(72);
      apb(1'b0, 8'h00, 32'h0);
      chk(rd, {24'h0, rows[i].cause});
    end
    repeat (100) @(posedge pclk);
    debug_active <= 1'b1;
    repeat (4) @(posedge pclk);
    apb(1'b0, 8'h0c, 32'h0);
    chk(rd, 32'h00000000);
    debug_active <= 1'b0;
    apb(1'b1, 8'h08, 32'h00000003);
    apb(1'b1, 8'h04, 32'h00000001);
    // let the count grow so a missed restart shows
    repeat (40) @(posedge pclk);
    apb(1'b1, 8'h00, 32'h00000055);
    apb(1'b1, 8'h00, 32'h000000aa);
    @(negedge pclk);
    chk({31'h0, sys_rst_n}, 32'h00000001);
    apb(1'b0, 8'h0c, 32'h0);
    chk({31'h0, rd <= 32'h1}, 32'h00000001);
    apb(1'b0, 8'h00, 32'h0);
    chk(rd, {24'h0, rows[5].cause});
    apb(1'b1, 8'h04, 32'h00000000);
    await_rst(400);
    chk({31'h0, n >= 200 && n <= 270}, 32'h00000001);
    boot(72);
    apb(1'b1, 8'h04, 32'h00000000);
    repeat (9000) @(posedge pclk);
    chk({31'h0, sys_rst_n}, 32'h00000001);
    apb(1'b1, 8'h00, 32'h00000012);
    await_rst(5);
    boot(72);
    apb(1'b0, 8'h00, 32'h0);
    chk(rd, 32'h00000020);
    apb(1'b1, 8'h08, 32'h00000002);
    apb(1'b1, 8'h04, 32'h00000001);
    apb(1'b1, 8'h00, 32'h00000055);
    await_rst(5);
    boot(72);
    apb(1'b0, 8'h00, 32'h0);
    chk(rd, 32'h00000020);
    apb(1'b1, 8'h08, 32'h00000002);
    apb(1'b1, 8'h04, 32'h00000001);
    // late service inside the last quarter is legal
    repeat (6200) @(posedge pclk);
    apb(1'b1, 8'h00, 32'h00000055);
    apb(1'b1, 8'h00, 32'h000000aa);
    @(negedge pclk);
    chk({31'h0, sys_rst_n}, 32'h00000001);
    @(posedge pclk);
    stop_active <= 1'b1;
    apb(1'b0, 8'h0c, 32'h0);
    hold_val = rd;
    repeat (50) @(posedge pclk);
    apb(1'b0, 8'h0c, 32'h0);
    chk(rd, hold_val);
    stop_active <= 1'b0;
    await_rst(9000);
    chk({31'h0, n >= 8150 && n <= 8200}, 32'h00000001);
    boot(72);
    apb(1'b0, 8'h00, 32'h0);
    chk(rd, 32'h00000020);
    ext_low <= 1'b1;
    await_rst(5);
    repeat (80) @(posedge pclk);
    ext_low <= 1'b0;
    boot(25);
    apb(1'b0, 8'h00, 32'h0);
    chk(rd, 32'h00000040);
    presetn <= 1'b0;
    @(posedge pclk);
    presetn <= 1'b1;
    boot(72);
    apb(1'b0, 8'h00, 32'h0);
    chk(rd, 32'h00000080);
    conclude();
  end

  // watchdog on the bench itself
  initial begin
    #200000;
    mismatches++;
    conclude();
  end
endmodule // reset_control_and_watchdog_tb

`default_nettype wire
